// [pkg/scc_pkg.sv]
// Constants, carriers and states of the secondary clock output control.
// Assumes one 125 MHz core clock; every pin input is synchronous to it.
package scc_pkg;

  // Configuration space offsets
  localparam logic [7:0]  SCC_OFS_BRIDGE_CTRL = 8'h3E; // Bridge control
  localparam logic [7:0]  SCC_OFS_CLK_GATE    = 8'h68; // Clock gating
  localparam logic [7:0]  SCC_OFS_PRI_FREQ    = 8'h6C; // Primary count
  localparam logic [7:0]  SCC_OFS_SEC_FREQ    = 8'h6E; // Secondary count

  // Values after reset
  localparam logic [15:0] SCC_CLK_GATE_RST    = 16'h0000;
  localparam logic [15:0] SCC_BRIDGE_CTRL_RST = 16'h0000;
  localparam logic [15:0] SCC_COUNT_RST       = 16'h0000;

  // Field positions
  localparam int          SCC_BCTRL_SEC_RST   = 6;  // Secondary reset bit
  localparam int          SCC_NUM_CLK         = 5;  // Clock outputs
  localparam int          SCC_MASK_BITS       = 9;  // Disable bits [8:0]
  localparam int          SCC_OUT4_GATE_BIT   = 8;  // Single bit for out 4

  // Reference edges per frequency measuring window, minus one
  localparam logic [3:0]  SCC_REF_WINDOW      = 4'hF;

  // Configuration access request
  typedef struct packed
  {
    logic        wr;     // Write strobe, one cycle
    logic        rd;     // Read strobe, one cycle
    logic [7:0]  addr;   // Byte offset of a 16-bit register
    logic [15:0] wdata;  // Write data
  } scc_cfg_req_t;

  // Hardware straps and static pins
  typedef struct packed
  {
    logic clock_off;        // sec_clock_off_strap
    logic ext_osc_select_n; // ext_osc_select_n
    logic pll_test_select;  // pll_test_select
    logic pri_pll_enable_n; // pri_pll_enable_n
    logic sec_pll_enable_n; // sec_pll_enable_n
  } scc_strap_t;

  // Mask loading phase
  typedef enum logic [1:0]
  {
    SCC_ST_SHIFT = 2'b01, // Primary reset held, mask stream accepted
    SCC_ST_RUN   = 2'b10  // Normal operation, config writes accepted
  } scc_state_t;

endpackage : scc_pkg

// [src/scc_clock_ctrl.sv]
// Secondary clock output control: source select, gating, mask stream,
// frequency measuring counters and secondary reset generation.
// Assumes all clock pins are slow enough to be sampled as levels at 125 MHz.
//
// Function
// - Mask stream shifts into gating register during reset
// - Mask held low enables all, high disables
// - Oscillator select low picks external oscillator source
// - Test select routes PLL test signals to 3,4
// - Primary PLL on when its enable is low
// - Reference clock counts primary and secondary clock frequency
// - Clock not stable holds secondary reset asserted
// - Outputs 4..1 follow the selected source frequency
// - Clock-off strap drives outputs 4..1 low
// - Strap low: disable bits float their outputs
// - Output 0 disabled when gate bits 1:0 are 11
// - Output 0 from source; floats under clock-off strap
// - Primary and secondary clocks time separate domains
// - Clock-off strap cannot be overridden by gate bits
// - Strap low enables all unless disable bits set
// - Secondary reset follows primary reset and control bit
// - Secondary PLL on when its enable is low
module scc_clock_ctrl
  import scc_pkg::*;
(
  // Core clock and reset
  input  wire  logic                    CLOCK,
  input  wire  logic                    RST_B,
  // Configuration access
  input  wire  scc_pkg::scc_cfg_req_t   CFG_REQ,
  output logic [15:0]                   CFG_RDATA,
  // Straps and clock pins
  input  wire  scc_pkg::scc_strap_t     STRAP,
  input  wire  logic                    PRI_CLOCK_IN,
  input  wire  logic                    SEC_CLOCK_IN,
  input  wire  logic                    EXT_OSC_IN,
  input  wire  logic                    FREQ_MEASURE_REF,
  input  wire  logic                    PRI_PLL_TEST,
  input  wire  logic                    SEC_PLL_TEST,
  // Mask stream
  input  wire  logic                    CLOCK_MASK_SERIAL_IN,
  input  wire  logic                    GPIO_SHIFT_CLK,
  input  wire  logic                    GPIO_SHIFT_EN,
  // Resets
  input  wire  logic                    PRI_RESET_IN_N,
  input  wire  logic                    SEC_CLOCK_STABLE,
  output logic                          SEC_RESET_OUT_N,
  // Clock outputs, enable low while driving
  output logic [SCC_NUM_CLK-1:0]        SEC_CLOCK_OUT,
  output logic [SCC_NUM_CLK-1:0]        SEC_CLOCK_OE_N,
  // PLL controls
  output logic                          PRI_PLL_ON,
  output logic                          SEC_PLL_ON
);

  import scc_pkg::*;

  scc_state_t        state_q;       // Mask loading phase
  scc_state_t        state_d;       // Next phase
  logic [15:0]       gate_q;        // secondary_clock_gate
  logic [15:0]       bctrl_q;       // bridge_ctrl
  logic              shift_clk_q;   // Previous shift clock level
  logic              ref_q;         // Previous reference level
  logic              pri_q;         // Previous primary clock level
  logic              sec_q;         // Previous secondary clock level
  logic [3:0]        win_q;         // Reference edges in this window
  logic [15:0]       pri_cnt_q;     // Primary edges in this window
  logic [15:0]       sec_cnt_q;     // Secondary edges in this window
  logic [15:0]       pri_freq_q;    // Last primary count
  logic [15:0]       sec_freq_q;    // Last secondary count
  logic [15:0]       rdata_q;       // Read data
  logic              sec_rst_n_q;   // Secondary reset output
  logic              pri_pll_q;     // Primary PLL on
  logic              sec_pll_q;     // Secondary PLL on
  logic [SCC_NUM_CLK-1:0] clk_q;    // Clock output levels
  logic [SCC_NUM_CLK-1:0] oe_n_q;   // Clock output enables

  // Decodes
  wire in_shift     = (state_q == SCC_ST_SHIFT);
  wire shift_fire   = in_shift & GPIO_SHIFT_EN
                    & GPIO_SHIFT_CLK & ~shift_clk_q;
  wire cfg_wr       = CFG_REQ.wr & (state_q == SCC_ST_RUN);
  wire wr_gate      = cfg_wr & (CFG_REQ.addr == SCC_OFS_CLK_GATE);
  wire wr_bctrl     = cfg_wr & (CFG_REQ.addr == SCC_OFS_BRIDGE_CTRL);
  wire ref_rise     = FREQ_MEASURE_REF & ~ref_q;
  wire win_end      = ref_rise & (win_q == SCC_REF_WINDOW);
  wire pri_rise     = PRI_CLOCK_IN & ~pri_q;
  wire sec_rise     = SEC_CLOCK_IN & ~sec_q;
  wire src_level    = STRAP.ext_osc_select_n ? PRI_CLOCK_IN
                                             : EXT_OSC_IN;
  wire sec_rst_req  = ~PRI_RESET_IN_N | bctrl_q[SCC_BCTRL_SEC_RST]
                    | ~SEC_CLOCK_STABLE;

  // Read selection; unmapped offsets read zero
  wire [15:0] rd_sel =
      (CFG_REQ.addr == SCC_OFS_CLK_GATE)    ? gate_q     :
      (CFG_REQ.addr == SCC_OFS_BRIDGE_CTRL) ? bctrl_q    :
      (CFG_REQ.addr == SCC_OFS_PRI_FREQ)    ? pri_freq_q :
      (CFG_REQ.addr == SCC_OFS_SEC_FREQ)    ? sec_freq_q : 16'h0000;

  // Phase follows the primary reset pin
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      SCC_ST_SHIFT:
      begin
        if (PRI_RESET_IN_N)
          state_d = SCC_ST_RUN;
      end
      SCC_ST_RUN:
      begin
        if (!PRI_RESET_IN_N)
          state_d = SCC_ST_SHIFT;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      state_q <= SCC_ST_SHIFT;
    else
      state_q <= state_d;
  end

  // Gating register: mask stream during reset, config writes after.
  // Bits land MSB-first so the ninth shift fills [8:0] completely.
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      gate_q <= SCC_CLK_GATE_RST;
    else if (shift_fire)
      gate_q[SCC_MASK_BITS-1:0] <= {CLOCK_MASK_SERIAL_IN,
                                    gate_q[SCC_MASK_BITS-1:1]};
    else if (wr_gate)
      gate_q <= CFG_REQ.wdata;
  end

  // Bridge control reverts while the primary reset is held
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      bctrl_q <= SCC_BRIDGE_CTRL_RST;
    else if (!PRI_RESET_IN_N)
      bctrl_q <= SCC_BRIDGE_CTRL_RST;
    else if (wr_bctrl)
      bctrl_q <= CFG_REQ.wdata;
  end

  // Edge history of the sampled pins
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      shift_clk_q <= 1'b0;
      ref_q       <= 1'b0;
      pri_q       <= 1'b0;
      sec_q       <= 1'b0;
    end
    else
    begin
      shift_clk_q <= GPIO_SHIFT_CLK;
      ref_q       <= FREQ_MEASURE_REF;
      pri_q       <= PRI_CLOCK_IN;
      sec_q       <= SEC_CLOCK_IN;
    end
  end

  // Measuring window of sixteen reference edges. Each bus clock is
  // counted on its own edges, so the two domains never share a count.
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      win_q      <= 4'h0;
      pri_cnt_q  <= SCC_COUNT_RST;
      sec_cnt_q  <= SCC_COUNT_RST;
      pri_freq_q <= SCC_COUNT_RST;
      sec_freq_q <= SCC_COUNT_RST;
    end
    else if (win_end)
    begin
      win_q      <= 4'h0;
      pri_freq_q <= pri_cnt_q;
      sec_freq_q <= sec_cnt_q;
      pri_cnt_q  <= {15'h0000, pri_rise};
      sec_cnt_q  <= {15'h0000, sec_rise};
    end
    else
    begin
      win_q     <= win_q + {3'h0, ref_rise};
      pri_cnt_q <= pri_cnt_q + {15'h0000, pri_rise};
      sec_cnt_q <= sec_cnt_q + {15'h0000, sec_rise};
    end
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
      rdata_q <= 16'h0000;
    else if (CFG_REQ.rd)
      rdata_q <= rd_sel;
  end

  // Secondary reset and PLL enables
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sec_rst_n_q <= 1'b0;
      pri_pll_q   <= 1'b0;
      sec_pll_q   <= 1'b0;
    end
    else
    begin
      sec_rst_n_q <= ~sec_rst_req;
      pri_pll_q   <= ~STRAP.pri_pll_enable_n;
      sec_pll_q   <= ~STRAP.sec_pll_enable_n;
    end
  end

  // Per-output gating. Outputs are resampled copies of the source, so
  // the frequency matches but the phase trails by one cycle.
  for (genvar k = 0; k < SCC_NUM_CLK; k++)
  begin : g_out
    logic dis;   // Disable bits for this output
    logic level; // Clock or test level to drive
    if (k == SCC_NUM_CLK - 1)
    begin : g_single
      assign dis = gate_q[SCC_OUT4_GATE_BIT];
    end
    else
    begin : g_pair
      assign dis = &gate_q[2*k+1:2*k];
    end
    if (k == 3)
    begin : g_pt
      assign level = STRAP.pll_test_select ? PRI_PLL_TEST
                                           : src_level;
    end
    else if (k == 4)
    begin : g_st
      assign level = STRAP.pll_test_select ? SEC_PLL_TEST
                                           : src_level;
    end
    else
    begin : g_src
      assign level = src_level;
    end

    // Strap wins over every disable bit
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
      if (!RST_B)
      begin
        clk_q[k]  <= 1'b0;
        oe_n_q[k] <= 1'b1;
      end
      else if (STRAP.clock_off)
      begin
        clk_q[k]  <= 1'b0;
        oe_n_q[k] <= (k == 0);
      end
      else
      begin
        clk_q[k]  <= level;
        oe_n_q[k] <= dis;
      end
    end
  end

  assign CFG_RDATA       = rdata_q;
  assign SEC_RESET_OUT_N = sec_rst_n_q;
  assign SEC_CLOCK_OUT   = clk_q;
  assign SEC_CLOCK_OE_N  = oe_n_q;
  assign PRI_PLL_ON      = pri_pll_q;
  assign SEC_PLL_ON      = sec_pll_q;

  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  sequence s_bctrl_set;
    wr_bctrl && CFG_REQ.wdata[SCC_BCTRL_SEC_RST] && PRI_RESET_IN_N;
  endsequence
  sequence s_rst_held;
    !SEC_RESET_OUT_N [*2];
  endsequence

  property p_mask_shift;
    shift_fire |=> gate_q[8] == $past(CLOCK_MASK_SERIAL_IN);
  endproperty
  a_mask_shift: assert property (p_mask_shift)
    else $error("mask bit not captured");

  property p_mask_low;
    shift_fire && !CLOCK_MASK_SERIAL_IN && gate_q[8:0] == 9'h000
      |=> gate_q[8:0] == 9'h000;
  endproperty
  a_mask_low: assert property (p_mask_low)
    else $error("low mask disabled an output");

  property p_osc_sel;
    !STRAP.clock_off && !STRAP.ext_osc_select_n && gate_q[1:0] != 2'h3
      |=> SEC_CLOCK_OUT[0] == $past(EXT_OSC_IN) && !SEC_CLOCK_OE_N[0];
  endproperty
  a_osc_sel: assert property (p_osc_sel)
    else $error("output 0 not from oscillator");

  property p_test3;
    !STRAP.clock_off && STRAP.pll_test_select
      |=> SEC_CLOCK_OUT[3] == $past(PRI_PLL_TEST);
  endproperty
  a_test3: assert property (p_test3)
    else $error("output 3 not carrying test");

  property p_pll;
    ##1 PRI_PLL_ON == !$past(STRAP.pri_pll_enable_n)
      && SEC_PLL_ON == !$past(STRAP.sec_pll_enable_n);
  endproperty
  a_pll: assert property (p_pll)
    else $error("PLL enable mismatch");

  property p_win;
    win_end |=> pri_freq_q == $past(pri_cnt_q)
      && sec_freq_q == $past(sec_cnt_q);
  endproperty
  a_win: assert property (p_win)
    else $error("frequency count not latched");

  property p_stable;
    !SEC_CLOCK_STABLE |=> !SEC_RESET_OUT_N;
  endproperty
  a_stable: assert property (p_stable)
    else $error("secondary reset released early");

  property p_off;
    STRAP.clock_off |=> SEC_CLOCK_OUT[4:1] == 4'h0
      && SEC_CLOCK_OE_N == 5'h01;
  endproperty
  a_off: assert property (p_off)
    else $error("clock-off strap not obeyed");

  property p_dis0;
    !STRAP.clock_off && gate_q[1:0] == 2'h3 |=> SEC_CLOCK_OE_N[0];
  endproperty
  a_dis0: assert property (p_dis0)
    else $error("output 0 not floated");

  property p_bctrl;
    s_bctrl_set ##1 bctrl_q[SCC_BCTRL_SEC_RST] |=> s_rst_held;
  endproperty
  a_bctrl: assert property (p_bctrl)
    else $error("secondary reset not held by control bit");

endmodule : scc_clock_ctrl

// [testbench/scc_clock_sink.sv]
// Model of the secondary bus loads that hang on the five clock pins.
// Assumes a pull-up on every clock line, so a floated pin reads high.
module scc_clock_sink
  import scc_pkg::*;
(
  // Core clock that samples the lines
  input  wire logic                   clock,
  // Pin levels and enables from the block
  input  wire logic [SCC_NUM_CLK-1:0] clk_out,
  input  wire logic [SCC_NUM_CLK-1:0] clk_oe_n,
  // Resolved lines and rising edges seen on line 1
  output logic [SCC_NUM_CLK-1:0]      line,
  output int unsigned                 rises
);
  timeunit 1ns;
  timeprecision 1ps;

  logic last_q = 1'b1; // Previous sample of line 1

  // A floated pin goes to the pull-up, never keeps its last level
  assign line = (clk_out & ~clk_oe_n) | clk_oe_n;

  initial rises = 0;

  // Count rising edges of the load on output 1
  always @(posedge clock)
  begin
    if (line[1] && !last_q)
      rises <= rises + 1;
    last_q <= line[1];
  end
endmodule : scc_clock_sink

// [testbench/secondary_clock_output_control_tb.sv]
// Self-checking bench of the secondary clock output control.
// Assumes the design and package are compiled first; clocks are levels.
module secondary_clock_output_control_tb;
  import scc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock = 1'b0;            // 125 MHz core clock
  logic rst_b = 1'b0;            // Core reset, low active
  scc_cfg_req_t cfg = '0;        // Config request
  scc_strap_t strap = 5'b01011;  // Ext osc off, PLLs off
  logic pri = 0, sec = 0, ext = 0, refc = 0; // Clock pin levels
  logic ptest = 0, stest = 0;    // PLL test levels
  logic mask = 0, sclk = 0, sen = 1; // Mask stream pins
  logic pri_rst_n = 0, stable = 1;   // Reset inputs
  logic run_clk = 0;             // Free-run the clock pins
  logic [7:0] cyc = 8'h00;       // Divider for the clock pins
  logic [15:0] rdata, v;         // Read data and last read
  logic sec_rst_n, pll_p, pll_s; // Reset and PLL outputs
  logic [4:0] sco, soe_n, line;  // Clock pins and loaded lines
  int unsigned rises, r0;        // Edges on line 1
  int n_mismatch = 0;
  int comparisons = 0;
  // Gate values and the enables they must give, low = driving
  logic [15:0] gv [8] = '{16'h0003, 16'h0002, 16'h000C, 16'h0030,
                          16'h00C0, 16'h0100, 16'hFE00, 16'h0000};
  logic [4:0]  ge [8] = '{5'h01, 5'h00, 5'h02, 5'h04,
                          5'h08, 5'h10, 5'h00, 5'h00};

  always #4 clock = ~clock;

  // Pin clocks: primary period 4, secondary 8, reference 16 cycles
  always @(posedge clock)
  begin
    cyc <= cyc + 8'h01;
    if (run_clk)
    begin
      pri <= cyc[1];
      sec <= cyc[2];
      refc <= cyc[3];
    end
  end

  scc_clock_ctrl uut (.CLOCK(clock), .RST_B(rst_b), .CFG_REQ(cfg),
    .CFG_RDATA(rdata), .STRAP(strap), .PRI_CLOCK_IN(pri),
    .SEC_CLOCK_IN(sec), .EXT_OSC_IN(ext), .FREQ_MEASURE_REF(refc),
    .PRI_PLL_TEST(ptest), .SEC_PLL_TEST(stest),
    .CLOCK_MASK_SERIAL_IN(mask), .GPIO_SHIFT_CLK(sclk),
    .GPIO_SHIFT_EN(sen), .PRI_RESET_IN_N(pri_rst_n),
    .SEC_CLOCK_STABLE(stable), .SEC_RESET_OUT_N(sec_rst_n),
    .SEC_CLOCK_OUT(sco), .SEC_CLOCK_OE_N(soe_n),
    .PRI_PLL_ON(pll_p), .SEC_PLL_ON(pll_s));

  scc_clock_sink load (.clock(clock), .clk_out(sco), .clk_oe_n(soe_n),
    .line(line), .rises(rises));

  // Let n edges land, then sample settled outputs
  task wait_n(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_n

  task check(input string name, input logic [15:0] exp,
             input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // Counts drift by a few edges with window alignment
  task check_range(input string name, input int lo, input int hi,
                   input int got);
    comparisons++;
    if (got < lo || got > hi)
    begin
      n_mismatch++;
      $display("unexpected %s expected %0d..%0d seen %0d", name, lo, hi,
               got);
    end
  endtask : check_range

  // One-cycle write strobe
  task cfg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    cfg <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    cfg.wr <= 1'b0;
  endtask : cfg_write

  // One-cycle read strobe; data holds until the next read
  task cfg_read(input logic [7:0] a);
    @(posedge clock);
    cfg <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock);
    cfg.rd <= 1'b0;
    wait_n(1);
    v = rdata;
  endtask : cfg_read

  // Nine shifts, first bit ends in bit 0; clock low 2 cycles, high 3 cycles
  task shift_word(input logic [8:0] w);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge clock);
      mask <= w[i];
      sclk <= 1'b0;
      repeat (2) @(posedge clock);
      sclk <= 1'b1;
      repeat (2) @(posedge clock);
    end
    wait_n(3);
  endtask : shift_word

  task end_of_test;
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test

  // Hang guard at 25000 cycles, well above the 1300 or so cycles the tests take
  initial
  begin
    #200000;
    n_mismatch++;
    end_of_test();
  end

  initial
  begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    wait_n(2);
    cfg_read(SCC_OFS_CLK_GATE);
    check("gate reset", SCC_CLK_GATE_RST, v);
    cfg_read(SCC_OFS_BRIDGE_CTRL);
    check("bridge reset", SCC_BRIDGE_CTRL_RST, v);
    check("sec reset in pri reset", 16'h0000, sec_rst_n);
    // Writes are refused while primary reset is held
    cfg_write(SCC_OFS_CLK_GATE, 16'hFFFF);
    cfg_read(SCC_OFS_CLK_GATE);
    check("gate locked", 16'h0000, v);
    shift_word(9'h1FF);
    check("mask high", 16'h001F, soe_n);
    cfg_read(SCC_OFS_CLK_GATE);
    check("gate shifted", 16'h01FF, v);
    shift_word(9'h103);
    check("mask order", 16'h0011, soe_n);
    cfg_read(SCC_OFS_CLK_GATE);
    check("gate order", 16'h0103, v);
    shift_word(9'h000);
    check("mask low", 16'h0000, soe_n);
    // Shift enable low refuses the whole stream
    @(posedge clock);
    sen <= 1'b0;
    shift_word(9'h1FF);
    check("mask gated", 16'h0000, soe_n);
    @(posedge clock);
    sen <= 1'b1;
    @(posedge clock);
    pri_rst_n <= 1'b1;
    wait_n(4);
    check("sec reset release", 16'h0001, sec_rst_n);
    // Stream is ignored once the primary reset is gone
    shift_word(9'h1FF);
    check("run shift refused", 16'h0000, soe_n);
    // Each disable field floats only its own output
    for (int i = 0; i < 8; i++)
    begin
      cfg_write(SCC_OFS_CLK_GATE, gv[i]);
      wait_n(3);
      check("gate enables", ge[i], soe_n);
      cfg_read(SCC_OFS_CLK_GATE);
      check("gate readback", gv[i], v);
    end
    cfg_read(8'h40);
    check("unmapped read", 16'h0000, v);
    // Source select: primary high, oscillator low, then swapped
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clock);
      strap.ext_osc_select_n <= (i == 0);
      pri <= (i < 2);
      ext <= (i == 2);
      wait_n(3);
      check("source level", (i == 1) ? 16'h0000 : 16'h001F, sco);
    end
    // Test mode replaces outputs 3 and 4 only
    @(posedge clock);
    strap <= '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    pri <= 1'b0;
    ptest <= 1'b1;
    wait_n(3);
    check("test levels", 16'h0008, sco);
    @(posedge clock);
    ptest <= 1'b0;
    stest <= 1'b1;
    wait_n(3);
    check("test levels swap", 16'h0010, sco);
    // Strap off wins over gate bits
    @(posedge clock);
    strap <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    pri <= 1'b1;
    cfg_write(SCC_OFS_CLK_GATE, 16'h0000);
    wait_n(3);
    check("strap off levels", 16'h0000, sco[4:1]);
    check("strap off enables", 16'h0001, soe_n);
    check("strap off lines", 16'h0001, line);
    @(posedge clock);
    strap.clock_off <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clock);
      strap.pri_pll_enable_n <= i[0];
      strap.sec_pll_enable_n <= i[1];
      wait_n(3);
      check("pri pll", !i[0], pll_p);
      check("sec pll", !i[1], pll_s);
    end
    @(posedge clock);
    stable <= 1'b0;
    wait_n(3);
    check("sec reset unstable", 16'h0000, sec_rst_n);
    @(posedge clock);
    stable <= 1'b1;
    cfg_write(SCC_OFS_BRIDGE_CTRL, 16'h0040);
    wait_n(3);
    check("sec reset bit", 16'h0000, sec_rst_n);
    cfg_write(SCC_OFS_BRIDGE_CTRL, 16'h0000);
    wait_n(3);
    check("sec reset bit clear", 16'h0001, sec_rst_n);
    // Free-running clocks: loads see the primary rate, counts latch
    @(posedge clock);
    run_clk <= 1'b1;
    wait_n(8);
    r0 = rises;
    repeat (256) @(posedge clock);
    check_range("out1 edges", 63, 65, rises - r0);
    repeat (600) @(posedge clock);
    cfg_read(SCC_OFS_PRI_FREQ);
    check_range("pri count", 56, 66, v);
    cfg_read(SCC_OFS_SEC_FREQ);
    check_range("sec count", 28, 33, v);
    end_of_test();
  end
endmodule : secondary_clock_output_control_tb
